// File: hdl/hwrs_map.vh
// Purpose: constants for the halt, wakeup and reset sequencer
// Assumes: 250 MHz system clock, oscillator enable derived inside the block
// Notes: register offsets are selectors on the plain register port
`ifndef HWRS_MAP_VH
`define HWRS_MAP_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HWRS_OFF_PORTG_DATA 4'h0
`define HWRS_OFF_PORTG_CFG 4'h1
`define HWRS_OFF_PORTL_DATA 4'h2
`define HWRS_OFF_PORTL_CFG 4'h3
`define HWRS_OFF_PORTD 4'h4
`define HWRS_OFF_STATUS_WORD 4'h5
`define HWRS_OFF_CTRL_ONE 4'h6
`define HWRS_OFF_CTRL_TWO 4'h7
`define HWRS_OFF_WAKE_EDGE 4'h8
`define HWRS_OFF_WAKE_EN 4'h9
`define HWRS_OFF_WAKE_PEND 4'hA
`define HWRS_OFF_SUP_CTRL 4'hB
`define HWRS_OFF_SUP_COUNT 4'hC
`define HWRS_OFF_STATE 4'hD
`define HWRS_OFF_PORTG_PINS 4'hE
// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define HWRS_HALT_BIT 7
`define HWRS_SUP_EN_BIT 0
`define HWRS_SUP_UDF_BIT 1
`define HWRS_CTRL_TWO_UDF_BIT 7
`define HWRS_ALL_ONES 8'hFF
`define HWRS_PORTD_RESET 4'hF
`define HWRS_CLK_XTAL 2'h0
`define HWRS_CLK_EXT 2'h1
`define HWRS_CLK_RC 2'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HWRS_CYCLE_DIV 10
`define HWRS_CYCLE_DIV_LAST 4'h9
`endif

// File: hdl/hwrs_sequencer.v
// Purpose: halt entry, wakeup exits, crystal start-up delay, supervision reset
// Assumes: one clock domain; pins are synchronised here; osc divide done in logic
// Notes: start-up delay is 256 prescaler steps from all ones
// ----------------------------------------------------------------
// Summary of operation
// [R1] supervision-timer reset keeps supervision enabled
// [R2] supervision-timer reset loads prescaler and counter with all ones
// [R3] supervision-timer reset keeps reset-enable bit and sets underflow flag
// [R4] supervision reset: ports L,G hi-z, D high, pc and L/G regs cleared
// [R5] supervision reset clears status word and control registers except underflow flag
// [R6] supervision reset clears wake edge and enable; pending left as is
// [R7] writing one to port G data bit seven enters halt
// [R8] halt gates off internal clock so state is frozen
// [R9] rising edge on restart pin exits halt, not with crystal option
// [R10] enabled port L wakeup event exits halt
// [R11] reset pin low during halt exits and resets
// [R12] crystal wakeup exit waits 256 cycles using prescaler and counter
// [R13] during start-up only oscillator runs; clocks follow after timeout
// [R14] instruction cycle is oscillator divided by ten, clocks the prescaler
// [R15] no delay for reset exit or rc/external option; counters still altered
// [R16] reset-pin exit restarts at address zero
// [R17] restart-pin or wakeup exit resumes after halting write, state kept
// [R18] crystal reset exit leaves accumulator and timer undefined
// [R19] crystal option: restart pin is oscillator output; else input and halt control
// [R20] when not halted restart pin reads as general input
// [R21] software puts two no-ops after the halting write
// [R22] supervision enable is write-once after reset
// [R23] wake events detected without the gated instruction clock
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "hwrs_map.vh"
module hwrs_sequencer
(
   input wire clock,
   input wire resetn,
   input wire [1:0] clock_option,
   input wire reset_pin_n,
   input wire halt_restart_in,
   input wire [7:0] port_l_in,
   input wire supervision_underflow,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   output reg halted,
   output reg osc_enable,
   output reg core_clock_enable,
   output reg cycle_tick,
   output reg oscillator_output_pin,
   output reg halt_restart_oe,
   output reg [7:0] port_l_out,
   output reg [7:0] port_l_oe,
   output reg [7:0] port_g_out,
   output reg [7:0] port_g_oe,
   output reg [3:0] port_d_out,
   output reg program_counter_clear,
   output reg core_state_undefined,
   output reg resume_after_halt
);
// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [2:0] ST_RUN = 3'b001;
localparam [2:0] ST_HALT = 3'b010;
localparam [2:0] ST_START = 3'b100;
// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
// reset pin idles high, so its stages reset to one and no false reset follows
reg [1:0] sync_rst;
reg [1:0] sync_g7;
reg [7:0] sync_l0;
reg [7:0] sync_l1;
reg g7_prev;
reg [7:0] l_prev;
always @(posedge clock or negedge resetn)
begin
   if (!resetn)
   begin
      sync_rst <= 2'h3;
      sync_g7 <= 2'h0;
      sync_l0 <= 8'h00;
      sync_l1 <= 8'h00;
      g7_prev <= 1'b0;
      l_prev <= 8'h00;
   end
   else
   begin
      sync_rst <= {sync_rst[0], reset_pin_n};
      sync_g7 <= {sync_g7[0], halt_restart_in};
      sync_l0 <= port_l_in;
      sync_l1 <= sync_l0;
      g7_prev <= sync_g7[1];
      l_prev <= sync_l1;
   end
end
// ----------------------------------------------------------------
// registers and state
// ----------------------------------------------------------------
reg [2:0] state;
reg [3:0] div_count;
reg [7:0] sup_prescaler;
reg [7:0] sup_counter;
reg supervision_reset_enable;
reg supervision_underflow_flag;
reg [7:0] processor_status_word;
reg [7:0] control_register_one;
reg [7:0] control_register_two;
reg [7:0] wakeup_edge_select;
reg [7:0] wakeup_enable_mask;
reg [7:0] wakeup_pending_flags;
reg [7:0] port_g_data;
reg [7:0] port_g_cfg;
reg [7:0] port_l_data;
reg [7:0] port_l_cfg;
reg [3:0] port_d_data;
// holds the restart pulse back until the reset pin is seen high again
reg pin_reset_latch;
wire crystal;
wire ext_reset;
wire sup_reset;
wire g7_rise;
wire [7:0] l_edge;
wire [7:0] next_pending;
wire wake_event;
wire wr_halt;
assign crystal = (clock_option == `HWRS_CLK_XTAL);
assign ext_reset = ~sync_rst[1];
// outside run the supervision timer is frozen or busy as the start-up timer
assign sup_reset = supervision_underflow & supervision_reset_enable & (state == ST_RUN);
// edges seen on the free-running system clock, not the gated core clock
assign g7_rise = sync_g7[1] & ~g7_prev & ~crystal; // [R9] [R23]
assign l_edge = (wakeup_edge_select & l_prev & ~sync_l1)
   | (~wakeup_edge_select & ~l_prev & sync_l1); // [R23]
assign next_pending = wakeup_pending_flags | l_edge;
assign wake_event = |(next_pending & wakeup_enable_mask); // [R10]
// the halting write still lands in port g data, so bit seven reads back set
assign wr_halt = reg_write & (reg_addr == `HWRS_OFF_PORTG_DATA)
   & reg_wdata[`HWRS_HALT_BIT]; // [R7]
always @(posedge clock or negedge resetn)
begin
   if (!resetn)
   begin
      state <= ST_RUN;
      div_count <= 4'h0;
      sup_prescaler <= `HWRS_ALL_ONES;
      sup_counter <= `HWRS_ALL_ONES;
      supervision_reset_enable <= 1'b0;
      supervision_underflow_flag <= 1'b0;
      processor_status_word <= 8'h00;
      control_register_one <= 8'h00;
      control_register_two <= 8'h00;
      wakeup_edge_select <= 8'h00;
      wakeup_enable_mask <= 8'h00;
      wakeup_pending_flags <= 8'h00;
      port_g_data <= 8'h00;
      port_g_cfg <= 8'h00;
      port_l_data <= 8'h00;
      port_l_cfg <= 8'h00;
      port_d_data <= `HWRS_PORTD_RESET;
      pin_reset_latch <= 1'b0;
      program_counter_clear <= 1'b1;
      core_state_undefined <= 1'b0;
      resume_after_halt <= 1'b0;
      cycle_tick <= 1'b0;
   end
   else
   begin
      program_counter_clear <= 1'b0;
      resume_after_halt <= 1'b0;
      // oscillator keeps running in start-up, so the divider does too
      if (state != ST_HALT)
         div_count <= (div_count == `HWRS_CYCLE_DIV_LAST) ? 4'h0 : div_count + 4'h1; // [R14]
      cycle_tick <= (state != ST_HALT) && (div_count == `HWRS_CYCLE_DIV_LAST); // [R14]
      wakeup_pending_flags <= next_pending;
      if (ext_reset)
      begin
         // pin reset: full init except wake pending, enable and flag cleared unlike supervision reset
         pin_reset_latch <= 1'b1;
         if (state == ST_HALT && crystal)
            core_state_undefined <= 1'b1; // [R18]
         state <= ST_RUN; // [R11] [R15]
         sup_prescaler <= `HWRS_ALL_ONES;
         sup_counter <= `HWRS_ALL_ONES;
         supervision_reset_enable <= 1'b0;
         supervision_underflow_flag <= 1'b0;
         processor_status_word <= 8'h00;
         control_register_one <= 8'h00;
         control_register_two <= 8'h00;
         wakeup_edge_select <= 8'h00;
         wakeup_enable_mask <= 8'h00;
         port_g_data <= 8'h00;
         port_g_cfg <= 8'h00;
         port_l_data <= 8'h00;
         port_l_cfg <= 8'h00;
         port_d_data <= `HWRS_PORTD_RESET;
      end
      else if (pin_reset_latch)
      begin
         pin_reset_latch <= 1'b0;
         program_counter_clear <= 1'b1; // [R16]
      end
      else if (sup_reset)
      begin
         // enable stays as it is; underflow flag is set
         supervision_underflow_flag <= 1'b1; // [R1] [R3]
         sup_prescaler <= `HWRS_ALL_ONES; // [R2]
         sup_counter <= `HWRS_ALL_ONES; // [R2]
         program_counter_clear <= 1'b1; // [R4]
         port_g_data <= 8'h00; // [R4]
         port_g_cfg <= 8'h00; // [R4]
         port_l_data <= 8'h00; // [R4]
         port_l_cfg <= 8'h00; // [R4]
         port_d_data <= `HWRS_PORTD_RESET; // [R4]
         processor_status_word <= 8'h00; // [R5]
         control_register_one <= 8'h00; // [R5]
         control_register_two <= 8'h00; // [R5]
         wakeup_edge_select <= 8'h00; // [R6]
         wakeup_enable_mask <= 8'h00; // [R6]
         state <= ST_RUN;
      end
      else
      begin
         case (state)
            ST_RUN:
            begin
               if (reg_write)
               begin
                  // flag stands until software writes again after the pin reset
                  core_state_undefined <= 1'b0;
                  case (reg_addr)
                     `HWRS_OFF_PORTG_DATA: port_g_data <= reg_wdata;
                     `HWRS_OFF_PORTG_CFG: port_g_cfg <= {2'h0, reg_wdata[5:0]};
                     `HWRS_OFF_PORTL_DATA: port_l_data <= reg_wdata;
                     `HWRS_OFF_PORTL_CFG: port_l_cfg <= reg_wdata;
                     `HWRS_OFF_PORTD: port_d_data <= reg_wdata[3:0];
                     `HWRS_OFF_STATUS_WORD: processor_status_word <= reg_wdata;
                     `HWRS_OFF_CTRL_ONE: control_register_one <= reg_wdata;
                     `HWRS_OFF_CTRL_TWO: control_register_two <= reg_wdata;
                     `HWRS_OFF_WAKE_EDGE: wakeup_edge_select <= reg_wdata;
                     `HWRS_OFF_WAKE_EN: wakeup_enable_mask <= reg_wdata;
                     `HWRS_OFF_WAKE_PEND:
                     begin
                        // an edge in the same cycle as the clear is kept
                        wakeup_pending_flags <= (wakeup_pending_flags & ~reg_wdata) | l_edge;
                     end
                     `HWRS_OFF_SUP_CTRL:
                     begin
                        if (reg_wdata[`HWRS_SUP_EN_BIT])
                           supervision_reset_enable <= 1'b1; // [R22]
                        if (reg_wdata[`HWRS_SUP_UDF_BIT])
                           supervision_underflow_flag <= 1'b0;
                     end
                     `HWRS_OFF_SUP_COUNT:
                     begin
                        sup_counter <= reg_wdata;
                        sup_prescaler <= `HWRS_ALL_ONES;
                     end
                     default: ;
                  endcase
               end
               if (wr_halt)
               begin
                  // entering halt loads both supervision counters
                  sup_prescaler <= `HWRS_ALL_ONES;
                  sup_counter <= `HWRS_ALL_ONES;
                  state <= ST_HALT; // [R7]
               end
            end
            ST_HALT:
            begin
               if (g7_rise || wake_event) // [R9] [R10]
               begin
                  sup_prescaler <= `HWRS_ALL_ONES; // [R12] [R15]
                  sup_counter <= `HWRS_ALL_ONES;
                  port_g_data[`HWRS_HALT_BIT] <= 1'b0;
                  // crystal start-up only on a port l wake; the restart pin is an output then
                  if (crystal && wake_event)
                     state <= ST_START; // [R12]
                  else
                  begin
                     state <= ST_RUN; // [R15]
                     resume_after_halt <= 1'b1; // [R17]
                  end
               end
            end
            ST_START:
            begin
               // prescaler paces the wait: 256 ticks from all ones down through zero
               if (cycle_tick)
               begin
                  sup_prescaler <= sup_prescaler - 8'h01; // [R14]
                  if (sup_prescaler == 8'h00)
                  begin
                     // prescaler underflow steps the counter once and ends the wait
                     sup_counter <= sup_counter - 8'h01; // [R12]
                     state <= ST_RUN; // [R13]
                     resume_after_halt <= 1'b1; // [R17]
                  end
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end
end
// ----------------------------------------------------------------
// clock gating and pin drive
// ----------------------------------------------------------------
always @(posedge clock or negedge resetn)
begin
   if (!resetn)
   begin
      halted <= 1'b0;
      osc_enable <= 1'b1;
      core_clock_enable <= 1'b0;
      oscillator_output_pin <= 1'b0;
      halt_restart_oe <= 1'b0;
      port_l_out <= 8'h00;
      port_l_oe <= 8'h00;
      port_g_out <= 8'h00;
      port_g_oe <= 8'h00;
      port_d_out <= `HWRS_PORTD_RESET;
   end
   else
   begin
      halted <= (state == ST_HALT);
      osc_enable <= (state != ST_HALT); // [R13]
      core_clock_enable <= (state == ST_RUN) & ~ext_reset; // [R8] [R13]
      oscillator_output_pin <= crystal & (state != ST_HALT) & div_count[0]; // [R19]
      // only the divided clock stands for the crystal output; the pad itself is analog
      halt_restart_oe <= crystal; // [R19]
      // enables follow config alone, so halt leaves the pads as they were
      port_l_out <= port_l_data;
      port_l_oe <= port_l_cfg; // [R4]
      port_g_out <= port_g_data;
      port_g_oe <= port_g_cfg; // [R4]
      port_d_out <= port_d_data; // [R4]
   end
end
// ----------------------------------------------------------------
// register read, data one cycle after strobe
// ----------------------------------------------------------------
always @(posedge clock or negedge resetn)
begin
   if (!resetn)
      reg_rdata <= 8'h00;
   // reads have no side effects, so polling cannot lose an event
   else if (reg_read)
   begin
      case (reg_addr)
         `HWRS_OFF_PORTG_DATA: reg_rdata <= port_g_data;
         `HWRS_OFF_PORTG_CFG: reg_rdata <= port_g_cfg;
         `HWRS_OFF_PORTL_DATA: reg_rdata <= port_l_data;
         `HWRS_OFF_PORTL_CFG: reg_rdata <= port_l_cfg;
         `HWRS_OFF_PORTD: reg_rdata <= {4'h0, port_d_data};
         `HWRS_OFF_STATUS_WORD: reg_rdata <= processor_status_word;
         `HWRS_OFF_CTRL_ONE: reg_rdata <= control_register_one;
         `HWRS_OFF_CTRL_TWO: reg_rdata <= {supervision_underflow_flag,
            control_register_two[6:0]}; // [R5]
         `HWRS_OFF_WAKE_EDGE: reg_rdata <= wakeup_edge_select;
         `HWRS_OFF_WAKE_EN: reg_rdata <= wakeup_enable_mask;
         `HWRS_OFF_WAKE_PEND: reg_rdata <= wakeup_pending_flags;
         `HWRS_OFF_SUP_CTRL: reg_rdata <= {6'h00, supervision_underflow_flag,
            supervision_reset_enable};
         `HWRS_OFF_SUP_COUNT: reg_rdata <= sup_counter;
         `HWRS_OFF_STATE: reg_rdata <= {5'h00, state};
         `HWRS_OFF_PORTG_PINS: reg_rdata <= {sync_g7[1] & ~crystal, 7'h00}; // [R20]
         default: reg_rdata <= 8'h00;
      endcase
   end
end
endmodule

// File: bench/hwrs_seq_props.sv
// Purpose: concurrent checks on the sequencer ports
// Assumes: one clock, resetn async active low
// Notes: pin latencies include the two-stage synchronisers
`timescale 1ns/10ps
module hwrs_seq_props
(
   input wire clock,
   input wire resetn,
   input wire [1:0] clock_option,
   input wire reset_pin_n,
   input wire halt_restart_in,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire halted,
   input wire osc_enable,
   input wire core_clock_enable,
   input wire cycle_tick,
   input wire oscillator_output_pin,
   input wire halt_restart_oe,
   input wire program_counter_clear,
   input wire core_state_undefined,
   input wire resume_after_halt
);
// --------
// checks
// --------
default clocking @(posedge clock); endclocking
default disable iff (!resetn);
chk_halt_entry: assert property (reg_write && reg_addr == 4'h0 && reg_wdata[7] &&
   core_clock_enable && reset_pin_n |-> ##[1:2] halted) else $error("halt not entered");
chk_clocks_frozen: assert property (halted |-> !cycle_tick && !core_clock_enable)
   else $error("clock active in halt");
chk_osc_halt_only: assert property ($fell(osc_enable) |-> ##[0:1] halted)
   else $error("oscillator stopped outside halt");
chk_startup_gate: assert property ($fell(halted) && clock_option == 2'h0 && reset_pin_n
   |=> (osc_enable && !core_clock_enable)[*8]) else $error("start-up delay skipped");
chk_tick_spacing: assert property (cycle_tick |=> !cycle_tick[*8])
   else $error("cycle tick too frequent");
chk_restart_exit: assert property (halted && clock_option != 2'h0
   && $rose(halt_restart_in) |-> ##[1:6] !halted) else $error("restart edge ignored");
chk_pin_role: assert property ($past(resetn) |->
   halt_restart_oe == (clock_option == 2'h0)
   && (clock_option == 2'h0 || !oscillator_output_pin)) else $error("restart pin role wrong");
chk_pin_reset_hold: assert property (!reset_pin_n[*5] |-> !core_clock_enable && !halted)
   else $error("pin reset not applied");
chk_pc_restart: assert property ($rose(reset_pin_n) |-> ##[1:5] program_counter_clear)
   else $error("no restart at zero");
chk_resume_pulse: assert property (resume_after_halt |=> !halted && !resume_after_halt)
   else $error("resume pulse malformed");
chk_undef_crystal: assert property (core_state_undefined |-> clock_option == 2'h0)
   else $error("undefined state without crystal");
endmodule
bind hwrs_sequencer hwrs_seq_props u_props (.clock(clock), .resetn(resetn),
   .clock_option(clock_option), .reset_pin_n(reset_pin_n), .halt_restart_in(halt_restart_in),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .halted(halted),
   .osc_enable(osc_enable), .core_clock_enable(core_clock_enable), .cycle_tick(cycle_tick),
   .oscillator_output_pin(oscillator_output_pin), .halt_restart_oe(halt_restart_oe),
   .program_counter_clear(program_counter_clear),
   .core_state_undefined(core_state_undefined), .resume_after_halt(resume_after_halt));

// File: bench/hwrs_pin_model.sv
// Purpose: external reset, restart, port L and underflow sources
// Assumes: every pin change lands just after a rising edge
// Notes: wake lines pulse so a later reset sees no stale edge
`timescale 1ns/10ps
module hwrs_pin_model
(
   input wire clock,
   output logic reset_pin_n,
   output logic halt_restart_in,
   output logic [7:0] port_l_in,
   output logic supervision_underflow
);
initial
begin
   reset_pin_n = 1'b1;
   halt_restart_in = 1'b0;
   port_l_in = 8'h00;
   supervision_underflow = 1'b0;
end
// --------
// pin actions
// --------
task hold_restart(input logic v);
   @(posedge clock);
   halt_restart_in <= v;
endtask
task wake_line(input int i);
   @(posedge clock);
   port_l_in[i] <= 1'b1;
   repeat (4) @(posedge clock);
   port_l_in[i] <= 1'b0;
endtask
// long pulses model a slow oscillator restart
task pulse_reset(input int n);
   @(posedge clock);
   reset_pin_n <= 1'b0;
   repeat (n) @(posedge clock);
   reset_pin_n <= 1'b1;
endtask
task underflow();
   @(posedge clock);
   supervision_underflow <= 1'b1;
   @(posedge clock);
   supervision_underflow <= 1'b0;
endtask
endmodule

// File: bench/hwrs_sequencer_tb_top.sv
// Purpose: directed scenarios for halt, wakeup and reset paths
// Assumes: clock_option changes only while resetn is low
// Notes: the whole 256 cycle crystal start-up is waited out
`timescale 1ns/10ps
`include "hwrs_map.vh"
module hwrs_sequencer_tb_top;
logic clock = 1'b0;
logic resetn = 1'b0;
logic [1:0] clock_option = 2'h1;
logic [3:0] reg_addr = 4'h0;
logic [7:0] reg_wdata = 8'h00;
logic reg_write = 1'b0;
logic reg_read = 1'b0;
logic [7:0] rd;
wire reset_pin_n, halt_restart_in, supervision_underflow, halted, osc_enable;
wire core_clock_enable, cycle_tick, oscillator_output_pin, halt_restart_oe;
wire program_counter_clear, core_state_undefined, resume_after_halt;
wire [7:0] port_l_in, reg_rdata, port_l_out, port_l_oe, port_g_out, port_g_oe;
wire [3:0] port_d_out;
int fails = 0;
int num_checks = 0;
always #2 clock = ~clock;
hwrs_sequencer dut (.clock(clock), .resetn(resetn), .clock_option(clock_option),
   .reset_pin_n(reset_pin_n), .halt_restart_in(halt_restart_in), .port_l_in(port_l_in),
   .supervision_underflow(supervision_underflow), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .halted(halted), .osc_enable(osc_enable),
   .core_clock_enable(core_clock_enable), .cycle_tick(cycle_tick),
   .oscillator_output_pin(oscillator_output_pin), .halt_restart_oe(halt_restart_oe),
   .port_l_out(port_l_out), .port_l_oe(port_l_oe), .port_g_out(port_g_out),
   .port_g_oe(port_g_oe), .port_d_out(port_d_out),
   .program_counter_clear(program_counter_clear),
   .core_state_undefined(core_state_undefined), .resume_after_halt(resume_after_halt));
hwrs_pin_model pins (.clock(clock), .reset_pin_n(reset_pin_n),
   .halt_restart_in(halt_restart_in), .port_l_in(port_l_in),
   .supervision_underflow(supervision_underflow));
// --------
// tasks
// --------
task check(input logic [7:0] seen, input logic [7:0] exp);
   num_checks++;
   if (seen !== exp)
   begin
      fails++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
   end
endtask
task conclude();
   $display("checks %0d mismatches %0d", num_checks, fails);
   if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
   else
      $display("TEST FAILED");
   $finish;
endtask
task wr(input logic [3:0] a, input logic [7:0] d);
   @(posedge clock);
   reg_addr <= a;
   reg_wdata <= d;
   reg_write <= 1'b1;
   @(posedge clock);
   reg_write <= 1'b0;
endtask
task rd_reg(input logic [3:0] a);
   @(posedge clock);
   reg_addr <= a;
   reg_read <= 1'b1;
   @(posedge clock);
   reg_read <= 1'b0;
   #1;
   rd = reg_rdata;
endtask
function logic pick(input int sel);
   case (sel)
      0: pick = halted;
      1: pick = core_clock_enable;
      2: pick = program_counter_clear;
      3: pick = resume_after_halt;
      default: pick = cycle_tick;
   endcase
endfunction
// bounded wait; a hang ends the run at once
task wait_on(input int sel, input logic v);
   int n;
   #1;
   for (n = 0; n < 400 && pick(sel) !== v; n++)
   begin
      @(posedge clock);
      #1;
   end
   check({7'h0, pick(sel)}, {7'h0, v});
   if (pick(sel) !== v)
      conclude();
endtask
task do_reset(input logic [1:0] opt);
   @(posedge clock);
   resetn <= 1'b0;
   clock_option <= opt;
   repeat (4) @(posedge clock);
   resetn <= 1'b1;
   repeat (3) @(posedge clock);
endtask
task enter_halt();
   wr(`HWRS_OFF_PORTG_DATA, 8'h80);
   repeat (2) @(posedge clock);
   wait_on(0, 1'b1);
endtask
// --------
// scenarios
// --------
logic [3:0] offs [7] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9};
initial
begin
   do_reset(`HWRS_CLK_EXT);
   check({6'h0, halt_restart_oe, oscillator_output_pin}, 8'h00);
   wait_on(4, 1'b1);
   @(posedge clock);
   #1;
   check({7'h0, cycle_tick}, 8'h00);
   pins.hold_restart(1'b1);
   repeat (2) @(posedge clock);
   rd_reg(`HWRS_OFF_PORTG_PINS);
   check(rd & 8'h80, 8'h80);
   pins.hold_restart(1'b0);
   repeat (2) @(posedge clock);
   rd_reg(`HWRS_OFF_PORTG_PINS);
   check(rd & 8'h80, 8'h00);
   wr(`HWRS_OFF_PORTL_DATA, 8'h5A);
   enter_halt();
   check(port_g_out, 8'h80);
   repeat (30) @(posedge clock);
   check({6'h0, osc_enable, core_clock_enable}, 8'h00);
   pins.hold_restart(1'b1);
   wait_on(3, 1'b1);
   wait_on(1, 1'b1);
   pins.hold_restart(1'b0);
   rd_reg(`HWRS_OFF_PORTL_DATA);
   check(rd, 8'h5A);
   check(port_l_out, 8'h5A);
   wr(`HWRS_OFF_WAKE_EDGE, 8'h00);
   wr(`HWRS_OFF_WAKE_EN, 8'h01);
   enter_halt();
   pins.wake_line(1);
   check({7'h0, halted}, 8'h01);
   fork
      pins.wake_line(0);
   join_none
   wait_on(3, 1'b1);
   rd_reg(`HWRS_OFF_WAKE_PEND);
   check(rd & 8'h01, 8'h01);
   do_reset(`HWRS_CLK_XTAL);
   check({7'h0, halt_restart_oe}, 8'h01);
   @(posedge clock);
   #1;
   rd = {7'h0, oscillator_output_pin};
   @(posedge clock);
   #1;
   check({7'h0, rd[0] ^ oscillator_output_pin}, 8'h01);
   wr(`HWRS_OFF_WAKE_EN, 8'h01);
   enter_halt();
   pins.hold_restart(1'b1);
   repeat (10) @(posedge clock);
   check({7'h0, halted}, 8'h01);
   pins.hold_restart(1'b0);
   fork
      pins.wake_line(0);
   join_none
   wait_on(0, 1'b0);
   repeat (2500) @(posedge clock);
   check({6'h0, osc_enable, core_clock_enable}, 8'h02);
   wait_on(3, 1'b1);
   wait_on(1, 1'b1);
   do_reset(`HWRS_CLK_XTAL);
   enter_halt();
   pins.pulse_reset(8);
   wait_on(2, 1'b1);
   wait_on(1, 1'b1);
   check({6'h0, halted, core_state_undefined}, 8'h01);
   do_reset(`HWRS_CLK_EXT);
   wr(`HWRS_OFF_SUP_CTRL, 8'h01);
   wr(`HWRS_OFF_SUP_CTRL, 8'h00);
   rd_reg(`HWRS_OFF_SUP_CTRL);
   check(rd & 8'h01, 8'h01);
   wr(`HWRS_OFF_PORTD, 8'h00);
   wr(`HWRS_OFF_CTRL_TWO, 8'h0F);
   wr(`HWRS_OFF_SUP_COUNT, 8'h12);
   for (int i = 0; i < 7; i++)
      wr(offs[i], 8'h0F);
   pins.underflow();
   wait_on(2, 1'b1);
   for (int i = 0; i < 7; i++)
   begin
      rd_reg(offs[i]);
      check(rd, 8'h00);
   end
   check(port_l_oe, 8'h00);
   check(port_g_oe, 8'h00);
   check({4'h0, port_d_out}, 8'h0F);
   rd_reg(`HWRS_OFF_SUP_CTRL);
   check(rd & 8'h03, 8'h03);
   rd_reg(`HWRS_OFF_SUP_COUNT);
   check(rd, 8'hFF);
   rd_reg(`HWRS_OFF_CTRL_TWO);
   check(rd, 8'h80);
   rd_reg(4'hF);
   check(rd, 8'h00);
   conclude();
end
endmodule
